//--- src/ssau_pkg.sv
// ==========================================================================
// saturating simd arithmetic unit: shared types and constants
// ==========================================================================
package ssau_pkg;

	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam int NUM_HALVES = 2;
	localparam int NUM_BYTES = 4;
	localparam int SAT_POS_W = 5;

	// accepted saturation bit positions
	localparam logic [SAT_POS_W-1:0] SPOS_SIGNED_MIN = 5'h01;
	localparam logic [SAT_POS_W-1:0] SPOS_SIGNED_MAX = 5'h10;
	localparam logic [SAT_POS_W-1:0] SPOS_UNSIGNED_MIN = 5'h00;
	localparam logic [SAT_POS_W-1:0] SPOS_UNSIGNED_MAX = 5'h0F;

	// ======================================================================
	// operation codes
	// ======================================================================
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_SIGNED_DUAL_HALF_CLAMP = 4'h1,
		OP_UNSIGNED_DUAL_HALF_CLAMP = 4'h2,
		OP_SAT_ADD_WORD = 4'h3,
		OP_SAT_SUB_WORD = 4'h4,
		OP_SAT_ADD_BYTES = 4'h5,
		OP_SAT_SUB_BYTES = 4'h6,
		OP_SAT_ADD_HALVES = 4'h7,
		OP_SAT_SUB_HALVES = 4'h8,
		OP_SAT_ADD_SUB_EXCHANGE = 4'h9,
		OP_SAT_SUB_ADD_EXCHANGE = 4'hA
	} ssau_op_t;

	// ======================================================================
	// application status register image
	// ======================================================================
	typedef struct packed {
		logic neg;
		logic zero;
		logic carry;
		logic ovf;
		logic sticky_sat;
	} ssau_status_t;

	localparam ssau_status_t STATUS_RESET = 5'h00;

	// ======================================================================
	// request and answer carriers
	// ======================================================================
	typedef struct packed {
		logic valid;
		ssau_op_t op;
		logic cond_pass;
		logic [SAT_POS_W-1:0] sat_pos;
		logic [WORD_W-1:0] first_operand_reg;
		logic [WORD_W-1:0] second_operand_reg;
	} ssau_issue_t;

	typedef struct packed {
		logic valid;
		logic wr_en;
		logic saturated;
		logic [WORD_W-1:0] data;
	} ssau_result_t;

	typedef struct packed {
		logic wr;
		ssau_status_t data;
	} ssau_status_wr_t;

endpackage : ssau_pkg

//--- src/ssau_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - signed dual-half clamp saturates each halfword to signed n bits
// - unsigned dual-half clamp saturates each halfword to unsigned n bits
// - bit position 0..15 unsigned, up to 16 signed
// - any clamped lane of dual-half clamp sets sticky flag
// - word add/sub computes full signed result, clamps to 32 bits
// - byte add/sub: four signed 8-bit lanes, each clamped
// - halfword add/sub: two signed 16-bit lanes, each clamped
// - add/sub results clamp to minus 2^(w-1) .. 2^(w-1)-1
// - word add/sub sets sticky flag only when result clamped
// - byte and halfword add/sub never touch sticky flag
// - sticky flag cleared only by reset or status write, read only by status read
// - no operation alters negative, zero, carry, overflow flags
// - add-sub-exchange top: first top plus second bottom, clamped
// - add-sub-exchange bottom: first bottom minus second top, clamped
// - sub-add-exchange top: first top minus second bottom, clamped
// - sub-add-exchange bottom: first bottom plus second top, clamped
// - exchange results clamp to -32768 .. 32767
// - failed condition writes no result and changes no flag
// - saturated means clamped value differs from exact value
module ssau_unit
	import ssau_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire ssau_issue_t issue,
	output logic issue_ready,
	input wire ssau_status_wr_t move_to_status_reg,
	input wire logic move_from_status_reg,
	output ssau_result_t result,
	output ssau_status_t status_rd_data,
	output logic status_rd_valid,
	output ssau_status_t application_status_reg
);

	// ======================================================================
	// signed and unsigned clamp helpers
	// ======================================================================
	function automatic logic [HALF_W:0] clamp_half_signed(
		input logic signed [HALF_W:0] x,
		input logic [SAT_POS_W-1:0] n
	);
		logic signed [HALF_W+1:0] hi;
		logic signed [HALF_W+1:0] lo;
		logic signed [HALF_W+1:0] xe;
		logic [SAT_POS_W-1:0] nn;
		logic [HALF_W-1:0] outv;
		logic sat;
		nn = n;
		if (nn < SPOS_SIGNED_MIN) begin
			nn = SPOS_SIGNED_MIN;
		end
		if (nn > SPOS_SIGNED_MAX) begin
			nn = SPOS_SIGNED_MAX;
		end
		hi = (18'sh00001 <<< (nn - 5'h01)) - 18'sh00001;
		lo = -hi - 18'sh00001;
		xe = {x[HALF_W], x};
		sat = 1'b0;
		outv = x[HALF_W-1:0];
		if (xe > hi) begin
			outv = hi[HALF_W-1:0];
			sat = 1'b1;
		end else if (xe < lo) begin
			outv = lo[HALF_W-1:0];
			sat = 1'b1;
		end
		return {sat, outv};
	endfunction : clamp_half_signed

	function automatic logic [HALF_W:0] clamp_half_unsigned(
		input logic signed [HALF_W:0] x,
		input logic [SAT_POS_W-1:0] n
	);
		logic signed [HALF_W+1:0] hi;
		logic signed [HALF_W+1:0] xe;
		logic [SAT_POS_W-1:0] nn;
		logic [HALF_W-1:0] outv;
		logic sat;
		nn = n;
		if (nn > SPOS_UNSIGNED_MAX) begin
			nn = SPOS_UNSIGNED_MAX;
		end
		hi = (18'sh00001 <<< nn) - 18'sh00001;
		xe = {x[HALF_W], x};
		sat = 1'b0;
		outv = x[HALF_W-1:0];
		if (xe > hi) begin
			outv = hi[HALF_W-1:0];
			sat = 1'b1;
		end else if (xe < 18'sh00000) begin
			outv = 16'h0000;
			sat = 1'b1;
		end
		return {sat, outv};
	endfunction : clamp_half_unsigned

	// ======================================================================
	// operation decode
	// ======================================================================
	logic take;
	logic is_sclamp;
	logic is_uclamp;
	logic is_word;
	logic is_bytes;
	logic is_halves;
	logic word_sub;
	logic bytes_sub;
	logic op_asx;
	logic op_sax;
	logic op_hsub;
	logic [WORD_W-1:0] opa;
	logic [WORD_W-1:0] opb;

	assign issue_ready = 1'b1;
	assign take = issue.valid;
	assign opa = issue.first_operand_reg;
	assign opb = issue.second_operand_reg;
	assign is_sclamp = (issue.op == OP_SIGNED_DUAL_HALF_CLAMP);
	assign is_uclamp = (issue.op == OP_UNSIGNED_DUAL_HALF_CLAMP);
	assign is_word = (issue.op == OP_SAT_ADD_WORD) || (issue.op == OP_SAT_SUB_WORD);
	assign word_sub = (issue.op == OP_SAT_SUB_WORD);
	assign is_bytes = (issue.op == OP_SAT_ADD_BYTES) || (issue.op == OP_SAT_SUB_BYTES);
	assign bytes_sub = (issue.op == OP_SAT_SUB_BYTES);
	assign op_asx = (issue.op == OP_SAT_ADD_SUB_EXCHANGE);
	assign op_sax = (issue.op == OP_SAT_SUB_ADD_EXCHANGE);
	assign op_hsub = (issue.op == OP_SAT_SUB_HALVES);
	assign is_halves = (issue.op == OP_SAT_ADD_HALVES) || op_hsub || op_asx || op_sax;

	// ======================================================================
	// dual-halfword clamp lanes
	// ======================================================================
	logic [WORD_W-1:0] sclamp_data;
	logic [WORD_W-1:0] uclamp_data;
	logic [NUM_HALVES-1:0] sclamp_sat;
	logic [NUM_HALVES-1:0] uclamp_sat;

	for (genvar h = 0; h < NUM_HALVES; h++) begin : g_clamp
		logic signed [HALF_W:0] src;
		logic [HALF_W:0] s_res;
		logic [HALF_W:0] u_res;
		assign src = {opb[h*HALF_W+HALF_W-1], opb[h*HALF_W +: HALF_W]};
		assign s_res = clamp_half_signed(src, issue.sat_pos);
		assign u_res = clamp_half_unsigned(src, issue.sat_pos);
		assign sclamp_data[h*HALF_W +: HALF_W] = s_res[HALF_W-1:0];
		assign uclamp_data[h*HALF_W +: HALF_W] = u_res[HALF_W-1:0];
		assign sclamp_sat[h] = s_res[HALF_W];
		assign uclamp_sat[h] = u_res[HALF_W];
	end

	// ======================================================================
	// 32-bit saturating add / subtract
	// ======================================================================
	localparam logic signed [WORD_W:0] WORD_MAX = 33'sh0_7FFF_FFFF;
	localparam logic signed [WORD_W:0] WORD_MIN = -33'sh0_8000_0000;
	logic signed [WORD_W:0] word_exact;
	logic [WORD_W-1:0] word_data;
	logic word_sat;

	always_comb begin
		if (word_sub) begin
			word_exact = $signed({opa[WORD_W-1], opa}) - $signed({opb[WORD_W-1], opb});
		end else begin
			word_exact = $signed({opa[WORD_W-1], opa}) + $signed({opb[WORD_W-1], opb});
		end
		word_sat = 1'b0;
		word_data = word_exact[WORD_W-1:0];
		if (word_exact > WORD_MAX) begin
			word_data = WORD_MAX[WORD_W-1:0];
			word_sat = 1'b1;
		end else if (word_exact < WORD_MIN) begin
			word_data = WORD_MIN[WORD_W-1:0];
			word_sat = 1'b1;
		end
	end

	// ======================================================================
	// byte lanes, each with its own adder so no carry crosses a lane
	// ======================================================================
	localparam logic signed [BYTE_W:0] BYTE_MAX = 9'sh07F;
	localparam logic signed [BYTE_W:0] BYTE_MIN = -9'sh080;
	logic [WORD_W-1:0] bytes_data;
	logic [NUM_BYTES-1:0] bytes_sat;

	for (genvar b = 0; b < NUM_BYTES; b++) begin : g_byte
		logic signed [BYTE_W:0] xa;
		logic signed [BYTE_W:0] xb;
		logic signed [BYTE_W:0] ex;
		assign xa = {opa[b*BYTE_W+BYTE_W-1], opa[b*BYTE_W +: BYTE_W]};
		assign xb = {opb[b*BYTE_W+BYTE_W-1], opb[b*BYTE_W +: BYTE_W]};
		assign ex = bytes_sub ? (xa - xb) : (xa + xb);
		always_comb begin
			bytes_sat[b] = 1'b0;
			bytes_data[b*BYTE_W +: BYTE_W] = ex[BYTE_W-1:0];
			if (ex > BYTE_MAX) begin
				bytes_data[b*BYTE_W +: BYTE_W] = BYTE_MAX[BYTE_W-1:0];
				bytes_sat[b] = 1'b1;
			end else if (ex < BYTE_MIN) begin
				bytes_data[b*BYTE_W +: BYTE_W] = BYTE_MIN[BYTE_W-1:0];
				bytes_sat[b] = 1'b1;
			end
		end
	end

	// ======================================================================
	// halfword lanes, plain and exchanged
	// ======================================================================
	localparam logic signed [HALF_W:0] HALF_MAX = 17'sh07FFF;
	localparam logic signed [HALF_W:0] HALF_MIN = -17'sh08000;
	logic [WORD_W-1:0] halves_data;
	logic [NUM_HALVES-1:0] halves_sat;

	for (genvar h = 0; h < NUM_HALVES; h++) begin : g_half
		localparam int XH = NUM_HALVES - 1 - h;
		logic signed [HALF_W:0] xa;
		logic signed [HALF_W:0] xb_same;
		logic signed [HALF_W:0] xb_swap;
		logic signed [HALF_W:0] xb;
		logic lane_sub;
		logic signed [HALF_W:0] ex;
		assign xa = {opa[h*HALF_W+HALF_W-1], opa[h*HALF_W +: HALF_W]};
		assign xb_same = {opb[h*HALF_W+HALF_W-1], opb[h*HALF_W +: HALF_W]};
		assign xb_swap = {opb[XH*HALF_W+HALF_W-1], opb[XH*HALF_W +: HALF_W]};
		// exchange variants pair each first-operand half with the other second-operand half
		assign xb = (op_asx || op_sax) ? xb_swap : xb_same;
		// top lane subtracts for sub-add, bottom lane subtracts for add-sub
		assign lane_sub = op_hsub || (op_asx && (h == 0)) || (op_sax && (h == 1));
		assign ex = lane_sub ? (xa - xb) : (xa + xb);
		always_comb begin
			halves_sat[h] = 1'b0;
			halves_data[h*HALF_W +: HALF_W] = ex[HALF_W-1:0];
			if (ex > HALF_MAX) begin
				halves_data[h*HALF_W +: HALF_W] = HALF_MAX[HALF_W-1:0];
				halves_sat[h] = 1'b1;
			end else if (ex < HALF_MIN) begin
				halves_data[h*HALF_W +: HALF_W] = HALF_MIN[HALF_W-1:0];
				halves_sat[h] = 1'b1;
			end
		end
	end

	// ======================================================================
	// result select
	// ======================================================================
	logic [WORD_W-1:0] sel_data;
	logic sel_sat;
	logic sel_sets_sticky;
	logic known_op;

	always_comb begin
		sel_data = '0;
		sel_sat = 1'b0;
		sel_sets_sticky = 1'b0;
		known_op = 1'b1;
		if (is_sclamp) begin
			sel_data = sclamp_data;
			sel_sat = |sclamp_sat;
			sel_sets_sticky = |sclamp_sat;
		end else if (is_uclamp) begin
			sel_data = uclamp_data;
			sel_sat = |uclamp_sat;
			sel_sets_sticky = |uclamp_sat;
		end else if (is_word) begin
			sel_data = word_data;
			sel_sat = word_sat;
			sel_sets_sticky = word_sat;
		end else if (is_bytes) begin
			sel_data = bytes_data;
			sel_sat = |bytes_sat;
			sel_sets_sticky = 1'b0;
		end else if (is_halves) begin
			sel_data = halves_data;
			sel_sat = |halves_sat;
			sel_sets_sticky = 1'b0;
		end else begin
			known_op = 1'b0;
		end
	end

	// ======================================================================
	// result register
	// ======================================================================
	logic executes;
	assign executes = take && known_op && issue.cond_pass;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result <= '0;
		end else begin
			result.valid <= take;
			result.wr_en <= executes;
			result.saturated <= executes && sel_sat;
			if (executes) begin
				result.data <= sel_data;
			end
		end
	end

	// ======================================================================
	// application status register
	// ======================================================================
	logic sticky_set;
	assign sticky_set = executes && sel_sets_sticky;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			application_status_reg <= STATUS_RESET;
		end else begin
			// condition flags follow only the status write path
			if (move_to_status_reg.wr) begin
				application_status_reg.neg <= move_to_status_reg.data.neg;
				application_status_reg.zero <= move_to_status_reg.data.zero;
				application_status_reg.carry <= move_to_status_reg.data.carry;
				application_status_reg.ovf <= move_to_status_reg.data.ovf;
			end
			// a saturation in the same cycle as a clearing write wins
			if (sticky_set) begin
				application_status_reg.sticky_sat <= 1'b1;
			end else if (move_to_status_reg.wr) begin
				application_status_reg.sticky_sat <= move_to_status_reg.data.sticky_sat;
			end
		end
	end

	// ======================================================================
	// status read port
	// ======================================================================
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_rd_data <= STATUS_RESET;
			status_rd_valid <= 1'b0;
		end else begin
			status_rd_valid <= move_from_status_reg;
			if (move_from_status_reg) begin
				status_rd_data <= application_status_reg;
			end
		end
	end

endmodule : ssau_unit

//--- test/ssau_unit_sva.sv
`timescale 1ns/100ps
module ssau_unit_chk
	import ssau_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire ssau_issue_t issue,
	input wire logic issue_ready,
	input wire ssau_status_wr_t move_to_status_reg,
	input wire logic move_from_status_reg,
	input wire ssau_result_t result,
	input wire ssau_status_t status_rd_data,
	input wire logic status_rd_valid,
	input wire ssau_status_t application_status_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	ssau_status_t st;
	logic wr;
	assign st = application_status_reg;
	assign wr = move_to_status_reg.wr;
	skip_write_a: assert property (issue.valid && (!issue.cond_pass || issue.op == OP_NONE)
		|=> result.valid && !result.wr_en && $stable(result.data)) else $error("skipped op wrote result");
	skip_flags_a: assert property (issue.valid && !issue.cond_pass && !wr |=> $stable(st))
		else $error("skipped op changed flags");
	cc_hold_a: assert property (!wr |=> $stable(st[4:1])) else $error("condition flags changed");
	sticky_keep_a: assert property (st.sticky_sat && !wr |=> st.sticky_sat) else $error("sticky cleared");
	lane_sticky_a: assert property (issue.valid && !st.sticky_sat && !wr && issue.op inside {OP_SAT_ADD_BYTES,
		OP_SAT_SUB_BYTES, OP_SAT_ADD_HALVES, OP_SAT_SUB_HALVES} |=> !st.sticky_sat) else $error("lane op set sticky");
	word_sticky_a: assert property (issue.valid && issue.cond_pass && !wr
		&& issue.op inside {OP_SAT_ADD_WORD, OP_SAT_SUB_WORD}
		|=> st.sticky_sat == ($past(st.sticky_sat) | result.saturated)) else $error("word sticky wrong");
	word_clamp_a: assert property (result.wr_en && result.saturated && $past(issue.op) == OP_SAT_ADD_WORD
		|-> result.data inside {32'h7FFFFFFF, 32'h80000000}) else $error("word clamp value wrong");
	clamp_sticky_a: assert property (issue.valid && issue.cond_pass && issue.op inside
		{OP_SIGNED_DUAL_HALF_CLAMP, OP_UNSIGNED_DUAL_HALF_CLAMP} |=> !result.saturated || st.sticky_sat)
		else $error("clamp did not set sticky");
	status_rd_a: assert property (move_from_status_reg |=> status_rd_valid && status_rd_data == $past(st))
		else $error("status read wrong");
	status_wr_a: assert property (wr && !issue.valid |=> st == $past(move_to_status_reg.data))
		else $error("status write lost");
endmodule : ssau_unit_chk

bind ssau_unit ssau_unit_chk chk (.clk, .rst, .issue, .issue_ready, .move_to_status_reg, .move_from_status_reg,
	.result, .status_rd_data, .status_rd_valid, .application_status_reg);

//--- test/ssau_core_model.sv
`timescale 1ns/100ps
module ssau_core_model
	import ssau_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire ssau_result_t result,
	output logic [WORD_W-1:0] dest_r
);
	// destination is a general register, never stack pointer or program counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dest_r <= '0;
		end else if (result.valid && result.wr_en) begin
			dest_r <= result.data;
		end
	end
endmodule : ssau_core_model

//--- test/test_saturating_simd_arith_unit.sv
`timescale 1ns/100ps
module test_saturating_simd_arith_unit;
	import ssau_pkg::*;
	logic clk;
	logic rst;
	ssau_issue_t issue;
	ssau_status_wr_t move_to_status_reg;
	logic move_from_status_reg;
	logic issue_ready;
	ssau_result_t result;
	ssau_status_t status_rd_data;
	logic status_rd_valid;
	ssau_status_t application_status_reg;
	logic [WORD_W-1:0] core_dest;
	int err_count;
	int cmp_count;
	logic sticky_exp;
	logic [WORD_W-1:0] last_data;

	ssau_unit DUT (.clk(clk), .rst(rst), .issue(issue), .issue_ready(issue_ready),
		.move_to_status_reg(move_to_status_reg), .move_from_status_reg(move_from_status_reg), .result(result),
		.status_rd_data(status_rd_data), .status_rd_valid(status_rd_valid),
		.application_status_reg(application_status_reg));
	ssau_core_model core (.clk(clk), .rst(rst), .result(result), .dest_r(core_dest));

	// ==================================================
	// reference and shared tasks
	// ==================================================
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : check

	function automatic longint lane(input logic [31:0] v, input int i, input int w);
		longint t;
		t = longint'({32'h0, v} >> (i * w));
		return (t <<< (64 - w)) >>> (64 - w);
	endfunction : lane

	function automatic logic [32:0] ref_op(input ssau_op_t op, input logic [31:0] a, input logic [31:0] b, input int n);
		int w;
		logic ng;
		logic s;
		longint x;
		longint lo;
		longint hi;
		logic [63:0] r;
		w = (op inside {OP_SAT_ADD_WORD, OP_SAT_SUB_WORD}) ? 32 : (op inside {OP_SAT_ADD_BYTES, OP_SAT_SUB_BYTES}) ? 8 : 16;
		s = 1'b0;
		r = '0;
		lo = -(64'sd1 <<< (w - 1));
		hi = -lo - 1;
		if (op == OP_SIGNED_DUAL_HALF_CLAMP) begin
			lo = -(64'sd1 <<< (n - 1));
			hi = -lo - 1;
		end
		if (op == OP_UNSIGNED_DUAL_HALF_CLAMP) begin
			lo = 0;
			hi = (64'sd1 <<< n) - 1;
		end
		for (int i = 0; i < 32 / w; i++) begin
			ng = op inside {OP_SAT_SUB_WORD, OP_SAT_SUB_BYTES, OP_SAT_SUB_HALVES}
				|| (op == OP_SAT_ADD_SUB_EXCHANGE && i == 0) || (op == OP_SAT_SUB_ADD_EXCHANGE && i == 1);
			x = lane(b, (op >= OP_SAT_ADD_SUB_EXCHANGE) ? 1 - i : i, w);
			if (op > OP_UNSIGNED_DUAL_HALF_CLAMP) x = lane(a, i, w) + (ng ? -x : x);
			if (x < lo || x > hi) s = 1'b1;
			x = (x < lo) ? lo : (x > hi) ? hi : x;
			r = r | ((64'(x) & ((64'h1 << w) - 1)) << (i * w));
		end
		return {s, r[31:0]};
	endfunction : ref_op

	task automatic run(input ssau_op_t op, input logic [31:0] a, input logic [31:0] b, input int n, input logic cp);
		logic [32:0] e;
		e = ref_op(op, a, b, n);
		@(posedge clk);
		issue <= '{1'b1, op, cp, 5'(n), a, b};
		@(posedge clk);
		issue.valid <= 1'b0;
		#1;
		if (cp && op != OP_NONE) begin
			last_data = e[31:0];
			if (op <= OP_SAT_SUB_WORD) sticky_exp |= e[32];
		end
		check(result.valid, 1'b1);
		check(issue_ready, 1'b1);
		check(result.wr_en, cp && op != OP_NONE);
		check(result.saturated, (cp && op != OP_NONE) ? e[32] : 1'b0);
		check(result.data, last_data);
		check(application_status_reg.sticky_sat, sticky_exp);
		// the core model registers the result one edge later
		@(posedge clk);
		#1;
		check(core_dest, last_data);
	endtask : run

	task automatic wr_status(input ssau_status_t d);
		@(posedge clk);
		move_to_status_reg <= '{1'b1, d};
		@(posedge clk);
		move_to_status_reg.wr <= 1'b0;
		#1;
		sticky_exp = d.sticky_sat;
		check(application_status_reg, d);
	endtask : wr_status

	task automatic rd_status(input ssau_status_t d);
		@(posedge clk);
		move_from_status_reg <= 1'b1;
		@(posedge clk);
		move_from_status_reg <= 1'b0;
		#1;
		check(status_rd_valid, 1'b1);
		check(status_rd_data, d);
	endtask : rd_status

	// ==================================================
	// scenarios
	// ==================================================
	task automatic t_table();
		logic [31:0] av [4] = '{32'h7FFF7F80, 32'h80000001, 32'h12345678, 32'h7FFFFFFF};
		logic [31:0] bv [4] = '{32'h00010180, 32'h7FFF8000, 32'h0FEDCBA9, 32'h00000001};
		int ns [4] = '{1, 16, 9, 5};
		int nu [4] = '{0, 15, 13, 8};
		for (int op = 1; op <= 10; op++) begin
			for (int j = 0; j < 4; j++) begin
				wr_status(5'h00);
				run(ssau_op_t'(op), av[j], bv[j], (op == 2) ? nu[j] : ns[j], 1'b1);
			end
		end
	endtask : t_table

	task automatic t_sticky();
		wr_status(5'h00);
		run(OP_SAT_ADD_WORD, 32'h7FFFFFFF, 32'h00000001, 0, 1'b1);
		run(OP_SAT_ADD_WORD, 32'h00000001, 32'h00000001, 0, 1'b1);
		run(OP_SAT_ADD_BYTES, 32'h7F7F7F7F, 32'h01010101, 0, 1'b1);
		rd_status(5'h01);
	endtask : t_sticky

	task automatic t_cond();
		wr_status(5'h00);
		run(OP_SAT_ADD_WORD, 32'h7FFFFFFF, 32'h00000001, 0, 1'b0);
		run(OP_NONE, 32'h00000005, 32'h00000007, 0, 1'b1);
	endtask : t_cond

	task automatic t_flags();
		wr_status(5'h1E);
		run(OP_SAT_SUB_WORD, 32'h80000000, 32'h00000001, 0, 1'b1);
		check(application_status_reg, 5'h1F);
		rd_status(5'h1F);
	endtask : t_flags

	task automatic t_lanes();
		wr_status(5'h00);
		run(OP_SAT_ADD_SUB_EXCHANGE, 32'h7FFF0001, 32'h00020001, 0, 1'b1);
		check(result.data, 32'h7FFFFFFF);
		run(OP_SAT_SUB_ADD_EXCHANGE, 32'h80000005, 32'h7FFF0001, 0, 1'b1);
		check(result.data, 32'h80007FFF);
		run(OP_SAT_SUB_HALVES, 32'h00007FFF, 32'h0001FFFF, 0, 1'b1);
		check(result.data, 32'hFFFF7FFF);
		run(OP_SAT_ADD_HALVES, 32'h7FFF0001, 32'h00010001, 0, 1'b1);
		check(result.data, 32'h7FFF0002);
		run(OP_SAT_SUB_BYTES, 32'h80007F01, 32'h0101FF02, 0, 1'b1);
		check(result.data, 32'h80FF7FFF);
		run(OP_UNSIGNED_DUAL_HALF_CLAMP, 32'h00000000, 32'h1FFF0005, 13, 1'b1);
		check(result.data, 32'h1FFF0005);
		run(OP_UNSIGNED_DUAL_HALF_CLAMP, 32'h00000000, 32'h2000FFFF, 13, 1'b1);
		check(result.data, 32'h1FFF0000);
		check(application_status_reg.sticky_sat, 1'b1);
		wr_status(5'h00);
		run(OP_SIGNED_DUAL_HALF_CLAMP, 32'h00000000, 32'h0100FE00, 9, 1'b1);
		check(result.data, 32'h00FFFF00);
		check(application_status_reg.sticky_sat, 1'b1);
	endtask : t_lanes

	task automatic conclude();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100us;
		err_count++;
		conclude();
	end

	initial begin
		rst = 1'b1;
		issue = '0;
		move_to_status_reg = '0;
		move_from_status_reg = 1'b0;
		err_count = 0;
		cmp_count = 0;
		sticky_exp = 1'b0;
		last_data = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(application_status_reg, STATUS_RESET);
		check(result, 35'h0);
		check(status_rd_valid, 1'b0);
		t_table();
		t_sticky();
		t_cond();
		t_flags();
		t_lanes();
		conclude();
	end
endmodule : test_saturating_simd_arith_unit
